//--- design/cfb_defs.svh
// Purpose: constants for the conditional flag branch unit
// Assumes: byte-wide program memory, 16-bit program counter
// Notes: included by the unit only; the package does not include it
//==============================================================
`ifndef CFB_DEFS_SVH
`define CFB_DEFS_SVH
`define CFB_PC_W 16
`define CFB_LEN_REL 2'h2
`define CFB_LEN_ABS 2'h3
`define CFB_CYC_REL 3'h3
`define CFB_CYC_ABS 3'h4
`define CFB_COND_NONZERO 2'h0
`define CFB_COND_NEG 2'h1
`define CFB_COND_NOOVF 2'h2
`define CFB_COND_NULL 2'h3
`endif

//--- design/cfb_pkg.sv
// Purpose: types for the conditional flag branch unit
// Assumes: nothing beyond the defs header
// Notes: state type only
package cfb_pkg;
    typedef enum logic [1:0] {CFB_IDLE, CFB_BUSY, CFB_DONE} cfb_state_type;
endpackage : cfb_pkg

//--- design/cfb_branch_unit.sv
// Purpose: resolve the four flag branches and load the program counter
// Assumes: flags, opcode and target are stable while START is high for one cycle
// Notes: flags are only read here, never written
`timescale 1ns/1ps
`include "cfb_defs.svh"
module cfb_branch_unit
    import cfb_pkg::*;
(
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic START,
    input wire logic [1:0] COND,
    input wire logic ABS_FORM,
    input wire logic [`CFB_PC_W-1:0] PC_IN,
    input wire logic [`CFB_PC_W-1:0] TARGET,
    input wire logic FLAG_Z,
    input wire logic FLAG_S,
    input wire logic FLAG_O,
    output logic BUSY,
    output logic DONE,
    output logic TAKEN,
    output logic [`CFB_PC_W-1:0] PC_OUT
);
    //==============================================================
    // reset release
    // the pin reset may drop at any time; its release is retimed so
    // that no flop of the unit leaves reset a cycle before another
    logic rst_meta;
    logic rst_n;
    logic next_rst_meta;
    logic next_rst_n;

    always_comb begin
        next_rst_meta = 1'b1;
        next_rst_n = rst_meta;
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= next_rst_meta;
            rst_n <= next_rst_n;
        end
    end

    //==============================================================
    // condition test
    // the flags are only read; nothing in this unit can write them back
    logic cond_ok;

    always_comb begin
        case (COND)
            `CFB_COND_NONZERO: cond_ok = (FLAG_Z == 1'b1);
            `CFB_COND_NEG: cond_ok = (FLAG_S == 1'b1);
            `CFB_COND_NOOVF: cond_ok = (FLAG_O == 1'b0);
            `CFB_COND_NULL: cond_ok = (FLAG_Z == 1'b0);
            default: cond_ok = 1'b0;
        endcase
    end

    //==============================================================
    // encoding length and cost
    logic [`CFB_PC_W-1:0] seq_pc;
    logic [2:0] issue_count;

    // fall-through address skips the whole encoding
    assign seq_pc = PC_IN + (ABS_FORM ? `CFB_PC_W'(`CFB_LEN_ABS) : `CFB_PC_W'(`CFB_LEN_REL));

    // the issue cycle itself counts, so the busy phase is one short of the cost
    assign issue_count = (ABS_FORM ? `CFB_CYC_ABS : `CFB_CYC_REL) - 3'h1;

    //==============================================================
    // sequencer state
    cfb_state_type state;
    cfb_state_type next_state;
    logic [2:0] count;
    logic [2:0] next_count;
    logic accept;
    logic last;

    // a start outside idle is dropped without any indication
    assign accept = (state == CFB_IDLE) && START;
    assign last = (state == CFB_BUSY) && (count == 3'h1);

    always_comb begin
        next_state = state;
        next_count = count;
        case (state)
            CFB_IDLE: begin
                if (accept) begin
                    next_count = issue_count;
                    next_state = CFB_BUSY;
                end
            end
            CFB_BUSY: begin
                next_count = count - 3'h1;
                if (last) begin
                    next_state = CFB_DONE;
                end
            end
            CFB_DONE: begin
                next_state = CFB_IDLE;
            end
            default: begin
                next_state = CFB_IDLE;
                next_count = 3'h0;
            end
        endcase
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            state <= CFB_IDLE;
            count <= 3'h0;
        end else begin
            state <= next_state;
            count <= next_count;
        end
    end

    //==============================================================
    // status outputs
    logic busy;
    logic next_busy;
    logic done;
    logic next_done;

    always_comb begin
        next_busy = busy;
        next_done = 1'b0;
        if (accept) begin
            next_busy = 1'b1;
        end
        if (last) begin
            next_busy = 1'b0;
            next_done = 1'b1;
        end
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            busy <= next_busy;
            done <= next_done;
        end
    end

    //==============================================================
    // branch result
    logic taken;
    logic next_taken;
    logic [`CFB_PC_W-1:0] pc;
    logic [`CFB_PC_W-1:0] next_pc;

    always_comb begin
        next_taken = taken;
        next_pc = pc;
        if (accept) begin
            // flags sampled at issue; later flag changes do not matter
            next_taken = cond_ok;
            next_pc = cond_ok ? TARGET : seq_pc;
        end
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            taken <= 1'b0;
            pc <= `CFB_PC_W'(0);
        end else begin
            taken <= next_taken;
            pc <= next_pc;
        end
    end

    //==============================================================
    // outputs
    // every output is a plain flop copy, so the core sees no glitches
    assign BUSY = busy;
    assign DONE = done;
    assign TAKEN = taken;
    assign PC_OUT = pc;
endmodule : cfb_branch_unit

//--- dv/cfb_branch_monitor.sv
// Purpose: port checks
// Assumes: one clock
// Notes: bound below
`timescale 1ns/1ps
module cfb_branch_monitor(
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic START,
    input wire logic ABS_FORM,
    input wire logic FLAG_Z,
    input wire logic FLAG_S,
    input wire logic FLAG_O,
    input wire logic BUSY,
    input wire logic DONE,
    input wire logic TAKEN,
    input wire logic [1:0] COND,
    input wire logic [15:0] PC_IN,
    input wire logic [15:0] TARGET,
    input wire logic [15:0] PC_OUT
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!NRST);
    wire go=START&&!BUSY&&!DONE;
    a_nz_hit: assert property(go&&COND==2'h0|=>TAKEN==$past(FLAG_Z))else $error("nz");
    a_neg_hit: assert property(go&&COND==2'h1|=>TAKEN==$past(FLAG_S))else $error("neg");
    a_novf_hit: assert property(go&&COND==2'h2|=>TAKEN!=$past(FLAG_O))else $error("ovf");
    a_null_hit: assert property(go&&COND==2'h3|=>TAKEN!=$past(FLAG_Z))else $error("null");
    a_fall_len: assert property(go|=>TAKEN||PC_OUT==16'($past(PC_IN)+($past(ABS_FORM)?16'h3:16'h2)))else $error("len");
    a_target_load: assert property(go|=>!TAKEN||PC_OUT==$past(TARGET))else $error("pc");
    a_rel_time: assert property(go&&!ABS_FORM|=>BUSY[*2]##1 DONE&&!BUSY)else $error("rel");
    a_abs_time: assert property(go&&ABS_FORM|=>BUSY[*3]##1 DONE&&!BUSY)else $error("abs");
endmodule : cfb_branch_monitor
bind cfb_branch_unit cfb_branch_monitor cfb_branch_monitor_i(.*);

//--- dv/cfb_flag_model.sv
// Purpose: status flags
// Assumes: want set off edge
// Notes: flags never written back
`timescale 1ns/1ps
module cfb_flag_model(input wire logic MCLK,input wire logic [2:0] want,output logic FLAG_Z,FLAG_S,FLAG_O);
    always_ff @(posedge MCLK) {FLAG_Z,FLAG_S,FLAG_O}<=want;
endmodule : cfb_flag_model

//--- dv/tb_top.sv
// Purpose: branch bench
// Assumes: flag model
// Notes: no random
`timescale 1ns/1ps
module tb_top;
    logic MCLK=0,NRST=0,START=0,ABS_FORM=0,FLAG_Z,FLAG_S,FLAG_O,BUSY,DONE,TAKEN;
    logic [1:0] COND=0;
    logic [2:0] want=0;
    logic [15:0] PC_IN=16'h1200,TARGET=16'hA5F0,PC_OUT;
    int fail_count=0,samples_checked=0;
    cfb_branch_unit cfb_branch_unit_i(.*);
    cfb_flag_model cfb_flag_model_i(.*);
    initial forever #12.5 MCLK=~MCLK;
    initial begin repeat(3000) @(posedge MCLK); fail_count++; summarize(); end
    task summarize;
        $display("fail_count=%0d samples_checked=%0d",fail_count,samples_checked);
        if (fail_count==0&&samples_checked>0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize
    task chk(input logic [15:0] got,exp);
        samples_checked++;
        if (got!==exp) begin
            fail_count++;
            $display("[FAIL] %0t %h %h",$time,got,exp);
        end
    endtask : chk
    // absolute runs retry START mid-op; a restart would delay the done pulse
    task sweep(input logic a);
        int n;
        logic t;
        for (int k=0;k<32;k++) begin
            t=k[4:3]==0?k[2]:k[4:3]==1?k[1]:k[4:3]==2?!k[0]:!k[2];
            want=k[2:0];
            @(negedge MCLK);
            {START,COND,ABS_FORM}={1'b1,k[4:3],a};
            for (n=1;n<9&&(n==1||!DONE);n++) begin @(negedge MCLK); START=a&&n==2; end
            chk(n[15:0],a?16'h5:16'h4);
            chk({15'h0,TAKEN},{15'h0,t});
            chk(PC_OUT,t?TARGET:PC_IN+(a?16'h3:16'h2));
        end
    endtask : sweep
    initial begin
        repeat(12) @(negedge MCLK);
        NRST=1;
        repeat(3) @(negedge MCLK);
        sweep(1'b0);
        sweep(1'b1);
        summarize();
    end
endmodule : tb_top
